// [verilog/svd_cfg.svh]
// Constants for the supply voltage detector controller.
`ifndef SVD_CFG_SVH
`define SVD_CFG_SVH
// ----------------------------------------
// Protection, field values and reset values
// ----------------------------------------
`define SVD_PROTECT_KEY 16'h0096
`define SVD_RESET_SELECT 4'ha
`define SVD_MODE_CONT 2'h0
`define SVD_THRESH_RESET 5'h1e
`define SVD_DEBUG_RUN_RESET 1'h1
`define SVD_DIV_BYPASS 3'h6
`define SVD_DIV_BASE 7'h04
// ----------------------------------------
// Timing in detector clock ticks
// ----------------------------------------
`define SVD_MASK_TICKS 11'h004
// The comparator stays powered for three ticks before its sample is taken.
// Two of them cover the synchroniser, which is still full of the unpowered
// output when the detector clock ticks on every ref_clk cycle.
`define SVD_ON_TICKS 11'h003
`define SVD_INTERVAL_M1 11'h100
`define SVD_INTERVAL_M2 11'h200
`define SVD_INTERVAL_M3 11'h400
`endif

// [verilog/svd_pkg.sv]
// Types shared by the supply voltage detector controller.
package svd_pkg;
	// Detector clock settings, written under protection.
	typedef struct packed {
		logic debugRun;
		logic [2:0] div;
		logic [1:0] src;
	} svd_clk_s;
	// Detector control settings, written under protection.
	typedef struct packed {
		logic senseSource;
		logic [1:0] succCount;
		logic [4:0] threshold;
		logic [3:0] resetSel;
		logic [1:0] intervalMode;
		logic detEnable;
	} svd_ctrl_s;
	// Sequencer states.
	typedef enum logic [2:0] {
		SVD_IDLE = 3'b000,
		SVD_MASK = 3'b001,
		SVD_CONT = 3'b010,
		SVD_WAIT = 3'b011,
		SVD_ON = 3'b100
	} svd_state_e;
endpackage

// [verilog/svd_ctrl.sv]
// Supply voltage detector controller: protection, clock gating, sequencing and events.
// Overview of operation
// - Sleep-stop halts detector, settings kept.
// - Debug without run bit halts detector.
// - Writing one clears the low-voltage flag.
// - Clearing detection enable stops detection.
// - Result is one when voltage below threshold.
// - Mode zero samples continuously every tick.
// - Low result sets the flag, and also raises reset if 0xa.
// - Continuous detection proceeds after masking time.
// - Intermittent modes power up, sample, power down.
// - Intermittent modes: event only after enough consecutive lows.
// - Thirty-two thresholds and sense source selectable.
// - Single interrupt source: low voltage.
// - Interrupt needs flag and enable both set.
// - Flag stays set until software clears.
`timescale 1ns/1ps
`include "svd_cfg.svh"

module svd_ctrl
	import svd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic keyWrite,
	input wire logic [15:0] keyData,
	input wire logic clkWrite,
	input wire svd_clk_s clkData,
	input wire logic ctrlWrite,
	input wire svd_ctrl_s ctrlData,
	input wire logic flagClear,
	input wire logic irqEnable,
	input wire logic [3:0] sourceTick,
	input wire logic sleepMode,
	input wire logic sleepStopSelect,
	input wire logic debugMode,
	input wire logic compLow,
	output logic unlocked,
	output svd_clk_s clkState,
	output svd_ctrl_s ctrlState,
	output logic comparatorOn,
	output logic detectionResult,
	output logic lowVoltageFlag,
	output logic irqRequest,
	output logic svdResetReq
);

	// ----------------------------------------
	// Protected settings
	// ----------------------------------------
	logic [15:0] protKey; // Last key written by software.
	logic [15:0] next_protKey;
	svd_clk_s next_clkState;
	svd_ctrl_s next_ctrlState;

	// Settings change only while the key holds the unlock value.
	always_comb begin
		next_protKey = keyWrite ? keyData : protKey;
		next_clkState = clkState;
		next_ctrlState = ctrlState;
		if (clkWrite && unlocked) begin
			next_clkState = clkData;
		end
		if (ctrlWrite && unlocked) begin
			next_ctrlState = ctrlData;
			// The count field only takes effect outside continuous mode.
			if (ctrlData.intervalMode == `SVD_MODE_CONT) begin
				next_ctrlState.succCount = ctrlState.succCount;
			end
		end
	end

	// Register the key and settings.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			protKey <= 16'h0000;
			clkState <= '{debugRun: `SVD_DEBUG_RUN_RESET, div: 3'h0, src: 2'h0};
			ctrlState <= '{senseSource: 1'b0, succCount: 2'h0, threshold: `SVD_THRESH_RESET,
				resetSel: 4'h0, intervalMode: 2'h0, detEnable: 1'b0};
		end else begin
			protKey <= next_protKey;
			clkState <= next_clkState;
			ctrlState <= next_ctrlState;
		end
	end

	assign unlocked = (protKey == `SVD_PROTECT_KEY);

	// ----------------------------------------
	// Detector clock tick
	// ----------------------------------------
	logic [6:0] divCnt; // Source ticks since the last detector tick.
	logic [6:0] next_divCnt;
	logic [6:0] divLimit;
	logic srcGated;
	logic detTick; // One detector clock period has passed.
	logic clkHalted;

	// Sleep-stop and debug without the run bit suspend the tick, so the divider holds, and the sequencer too while detection stays enabled.
	assign clkHalted = (sleepMode && sleepStopSelect)
		|| (debugMode && !clkState.debugRun);
	assign srcGated = sourceTick[clkState.src] && !clkHalted;
	assign divLimit = (clkState.div >= `SVD_DIV_BYPASS) ? 7'h00
		: 7'((`SVD_DIV_BASE << clkState.div) - 7'h01);
	assign detTick = srcGated && (divCnt >= divLimit);

	// Divide the selected source down to the detector clock.
	always_comb begin
		next_divCnt = divCnt;
		if (detTick) begin
			next_divCnt = 7'h00;
		end else if (srcGated) begin
			next_divCnt = divCnt + 7'h01;
		end
	end

	// Register the divider.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt <= 7'h00;
		end else begin
			divCnt <= next_divCnt;
		end
	end

	// ----------------------------------------
	// Comparator synchroniser
	// ----------------------------------------
	logic compMeta; // First stage, read only by the second.
	logic compSync; // Voltage below threshold, synchronised.

	// The analog output changes with no regard to ref_clk.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compMeta <= 1'b0;
			compSync <= 1'b0;
		end else begin
			compMeta <= compLow;
			compSync <= compMeta;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	svd_state_e state;
	svd_state_e next_state;
	logic [10:0] timer; // Detector ticks spent in the current state.
	logic [10:0] next_timer;
	logic [10:0] interval;
	logic [1:0] lowCount; // Consecutive low samples so far.
	logic [1:0] next_lowCount;
	logic [2:0] lowNeeded;
	logic [1:0] effMode;
	logic next_result;
	logic lowEvent; // A detection that must raise the flag or reset.
	logic next_flag;
	logic next_resetReq;

	// A pending detector reset forces continuous operation.
	assign effMode = svdResetReq ? `SVD_MODE_CONT : ctrlState.intervalMode;
	assign lowNeeded = 3'({1'b0, ctrlState.succCount}) + 3'h1;
	always_comb begin
		case (effMode)
			2'h1: interval = `SVD_INTERVAL_M1;
			2'h2: interval = `SVD_INTERVAL_M2;
			default: interval = `SVD_INTERVAL_M3;
		endcase
	end

	// Next state, timer, result and the low-voltage event.
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_lowCount = lowCount;
		next_result = detectionResult;
		lowEvent = 1'b0;
		if (!ctrlState.detEnable) begin
			next_state = SVD_IDLE;
			next_timer = 11'h000;
			next_lowCount = 2'h0;
		end else if (detTick) begin
			case (state)
				SVD_IDLE: begin
					next_state = SVD_MASK;
					next_timer = 11'h000;
				end
				SVD_MASK: begin
					// Results are not trusted until the masking time is over.
					next_result = compSync;
					next_timer = timer + 11'h001;
					if (next_timer >= `SVD_MASK_TICKS) begin
						next_timer = 11'h000;
						next_state = (effMode == `SVD_MODE_CONT) ? SVD_CONT : SVD_WAIT;
					end
				end
				SVD_CONT: begin
					next_result = compSync;
					lowEvent = compSync;
					if (effMode != `SVD_MODE_CONT) begin
						next_state = SVD_WAIT;
						next_timer = 11'h000;
					end
				end
				SVD_WAIT: begin
					next_timer = timer + 11'h001;
					if (effMode == `SVD_MODE_CONT) begin
						next_state = SVD_CONT;
						next_timer = 11'h000;
					end else if (next_timer >= interval) begin
						next_state = SVD_ON;
						next_timer = 11'h000;
					end
				end
				SVD_ON: begin
					next_timer = timer + 11'h001;
					if (next_timer >= `SVD_ON_TICKS) begin
						next_result = compSync;
						next_state = SVD_WAIT;
						next_timer = 11'h000;
						if (!compSync) begin
							next_lowCount = 2'h0;
						end else if (3'({1'b0, lowCount}) + 3'h1 >= lowNeeded) begin
							lowEvent = 1'b1;
						end else begin
							next_lowCount = lowCount + 2'h1;
						end
					end
				end
				default: begin
					next_state = SVD_IDLE;
				end
			endcase
		end
	end

	// Flag and reset request. A new event beats a clear in the same cycle.
	always_comb begin
		next_flag = lowVoltageFlag;
		if (flagClear) begin
			next_flag = 1'b0;
		end
		if (lowEvent) begin
			next_flag = 1'b1;
		end
		next_resetReq = svdResetReq;
		if (lowEvent && ctrlState.resetSel == `SVD_RESET_SELECT) begin
			next_resetReq = 1'b1;
		end else if (!ctrlState.detEnable || (detTick && state == SVD_CONT && !compSync)) begin
			// The reset lifts once the supply reads good again.
			next_resetReq = 1'b0;
		end
	end

	// Register the sequencer and its outputs.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SVD_IDLE;
			timer <= 11'h000;
			lowCount <= 2'h0;
			detectionResult <= 1'b0;
			lowVoltageFlag <= 1'b0;
			svdResetReq <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			lowCount <= next_lowCount;
			detectionResult <= next_result;
			lowVoltageFlag <= next_flag;
			svdResetReq <= next_resetReq;
		end
	end

	// The comparator is powered only while it has to look.
	assign comparatorOn = (state == SVD_MASK) || (state == SVD_CONT) || (state == SVD_ON);
	// One interrupt line, the low-voltage request, gated by its enable.
	assign irqRequest = lowVoltageFlag && irqEnable;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irqRequest == (lowVoltageFlag && irqEnable))
		else $error("Interrupt request not flag and enable.");
	AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lowVoltageFlag && !flagClear |=> lowVoltageFlag)
		else $error("Flag dropped without a clear.");
	AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		flagClear && !lowEvent |=> !lowVoltageFlag)
		else $error("Flag not cleared by write of one.");
	AST_LOCKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctrlWrite && !unlocked && !clkWrite |=> $stable(ctrlState))
		else $error("Control changed while protected.");
	AST_DISABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctrlState.detEnable |=> !comparatorOn && lowCount == 2'h0)
		else $error("Detector active while disabled.");
	AST_DEBUG_HALT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		debugMode && !clkState.debugRun && ctrlState.detEnable
		|=> $stable(state) && $stable(timer))
		else $error("Detector ran in debug without run bit.");
	AST_SLEEP_HALT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sleepMode && sleepStopSelect |-> !detTick)
		else $error("Detector ticked during sleep-stop.");
	AST_CONT_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == SVD_CONT && detTick && ctrlState.detEnable
		|=> detectionResult == $past(compSync) ##0 (lowVoltageFlag || !$past(compSync)))
		else $error("Continuous sample not loaded.");
	AST_RESET_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(svdResetReq) |-> $past(ctrlState.resetSel) == `SVD_RESET_SELECT)
		else $error("Reset raised without reset select.");
	AST_LOW_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state == SVD_ON && next_state == SVD_WAIT && !compSync && ctrlState.detEnable
		|=> lowCount == 2'h0 && !$rose(lowVoltageFlag))
		else $error("Low counter kept after high sample.");

endmodule

// [verif/svd_comp_model.sv]
// Behavioural model of the analog comparator behind the detector controller.
`timescale 1ns/1ps
module svd_comp_model
	import svd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic powered,
	input wire svd_ctrl_s ctrl,
	input wire logic [4:0] vddLevel,
	input wire logic [4:0] extLevel,
	output logic compLow
);
	// The level under test is picked by the sense source.
	logic [4:0] level;
	// An unpowered comparator output means nothing, so it wobbles every cycle.
	logic idleBit;
	assign level = ctrl.senseSource ? extLevel : vddLevel;
	initial idleBit = 1'b0;
	always @(posedge ref_clk) begin
		idleBit <= ~idleBit;
	end
	// Below threshold reads as low.
	assign compLow = powered ? (level < ctrl.threshold) : idleBit;
endmodule

// [verif/svd_ctrl_test.sv]
// Self-checking bench for the supply voltage detector controller.
`timescale 1ns/1ps
module svd_ctrl_test
	import svd_pkg::*;
;
	// ----
	// Stimulus and observed signals
	// ----
	logic ref_clk, rst_n, keyWrite, clkWrite, ctrlWrite, flagClear, irqEnable;
	logic sleepMode, sleepStopSelect, debugMode, compLow, unlocked, comparatorOn;
	logic detectionResult, lowVoltageFlag, irqRequest, svdResetReq;
	logic [15:0] keyData;
	logic [3:0] sourceTick;
	logic [4:0] vddLevel, extLevel;
	svd_clk_s clkData, clkState;
	svd_ctrl_s ctrlData, ctrlState;
	int errors, n_compared, cycles;
	svd_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .keyWrite(keyWrite),
		.keyData(keyData), .clkWrite(clkWrite), .clkData(clkData),
		.ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .flagClear(flagClear),
		.irqEnable(irqEnable), .sourceTick(sourceTick), .sleepMode(sleepMode),
		.sleepStopSelect(sleepStopSelect), .debugMode(debugMode), .compLow(compLow),
		.unlocked(unlocked), .clkState(clkState), .ctrlState(ctrlState),
		.comparatorOn(comparatorOn), .detectionResult(detectionResult),
		.lowVoltageFlag(lowVoltageFlag), .irqRequest(irqRequest),
		.svdResetReq(svdResetReq));
	svd_comp_model cmp (.ref_clk(ref_clk), .powered(comparatorOn), .ctrl(ctrlState),
		.vddLevel(vddLevel), .extLevel(extLevel), .compLow(compLow));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Hang guard: the whole run needs a little over a thousand cycles.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			conclude();
		end
	end
	// ----
	// Shared tasks
	// ----
	task automatic conclude();
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits n edges and lets their updates land before anything is sampled.
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wrKey(input logic [15:0] v);
		@(posedge ref_clk);
		keyWrite <= 1'b1;
		keyData <= v;
		@(posedge ref_clk);
		keyWrite <= 1'b0;
		tick(0);
	endtask
	task automatic wrClk(input svd_clk_s v);
		@(posedge ref_clk);
		clkWrite <= 1'b1;
		clkData <= v;
		@(posedge ref_clk);
		clkWrite <= 1'b0;
		tick(0);
	endtask
	task automatic wrCtrl(input logic [14:0] v);
		@(posedge ref_clk);
		ctrlWrite <= 1'b1;
		ctrlData <= v;
		@(posedge ref_clk);
		ctrlWrite <= 1'b0;
		tick(0);
	endtask
	task automatic vdd(input logic [4:0] v);
		@(posedge ref_clk);
		vddLevel <= v;
	endtask
	// Writes one to the low-voltage flag for a single cycle.
	task automatic clrFlag();
		@(posedge ref_clk);
		flagClear <= 1'b1;
		@(posedge ref_clk);
		flagClear <= 1'b0;
		tick(0);
	endtask
	// Disables detection and clears the flag, leaving the block idle.
	task automatic t_off();
		wrCtrl(15'h0800);
		clrFlag();
		tick(3);
		chk(comparatorOn, 1'b0);
		chk(svdResetReq, 1'b0);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_lock();
		chk(clkState, 6'h20);
		chk(ctrlState, 15'h0f00);
		wrCtrl(15'h0801);
		tick(2);
		chk(ctrlState, 15'h0f00);
		wrKey(16'h0096);
		chk(unlocked, 1'b1);
		wrClk(6'h19);
		wrKey(16'h0095);
		chk(unlocked, 1'b0);
		wrClk(6'h3f);
		tick(2);
		chk(clkState, 6'h19);
		wrKey(16'h0096);
	endtask
	task automatic t_cont();
		// Fields first, then flag clear and enable, detection last.
		wrCtrl(15'h2800);
		clrFlag();
		irqEnable <= 1'b1;
		wrCtrl(15'h2801);
		// A count written in continuous mode is dropped.
		chk(ctrlState, 15'h0801);
		tick(12);
		chk(comparatorOn, 1'b1);
		chk(detectionResult, 1'b0);
		vdd(5'h08);
		tick(6);
		chk(detectionResult, 1'b1);
		chk({lowVoltageFlag, irqRequest, svdResetReq}, 3'h6);
		irqEnable <= 1'b0;
		tick(1);
		chk(irqRequest, 1'b0);
		vdd(5'h18);
		tick(6);
		chk({detectionResult, lowVoltageFlag}, 2'h1);
		flagClear <= 1'b1;
		tick(1);
		flagClear <= 1'b0;
		tick(1);
		chk(lowVoltageFlag, 1'b0);
		extLevel <= 5'h08;
		wrCtrl(15'h4801);
		tick(6);
		chk(detectionResult, 1'b1);
		wrCtrl(15'h4381);
		tick(6);
		chk(detectionResult, 1'b0);
		t_off();
	endtask
	task automatic t_rsel();
		vdd(5'h08);
		wrCtrl(15'h0851);
		tick(12);
		chk({detectionResult, svdResetReq, irqRequest}, 3'h6);
		t_off();
	endtask
	// how: 0 sleep with stop, 1 debug without run bit, 2 debug with run bit,
	// 3 sleep with the detector clock kept running.
	task automatic t_halt(input int how);
		wrClk(how == 2 ? 6'h39 : 6'h19);
		vdd(5'h18);
		wrCtrl(15'h0801);
		tick(12);
		@(posedge ref_clk);
		debugMode <= (how == 1 || how == 2);
		sleepMode <= (how == 0 || how == 3);
		sleepStopSelect <= (how != 3);
		vddLevel <= 5'h08;
		tick(8);
		chk(detectionResult, how >= 2);
		debugMode <= 1'b0;
		sleepMode <= 1'b0;
		tick(6);
		chk(detectionResult, 1'b1);
		t_off();
	endtask
	// Samples go low, high, low, low; two lows in a row are needed.
	task automatic t_inter();
		logic [4:0] lvl [5] = '{5'h18, 5'h08, 5'h18, 5'h08, 5'h08};
		int rises, falls, offs;
		logic prev;
		rises = 0;
		falls = 0;
		offs = 0;
		prev = 1'b0;
		vdd(lvl[0]);
		wrCtrl(15'h1803);
		for (int i = 0; i < 3000 && lowVoltageFlag !== 1'b1; i++) begin
			tick(1);
			rises += (comparatorOn && !prev);
			falls += (!comparatorOn && prev);
			offs += !comparatorOn;
			if (!comparatorOn && prev && falls < 5)
				vddLevel <= lvl[falls];
			prev = comparatorOn;
		end
		chk(rises, 5);
		chk(offs / 256, 4);
		chk(detectionResult, 1'b1);
		t_off();
	endtask
	initial begin
		{rst_n, keyWrite, clkWrite, ctrlWrite, flagClear, irqEnable} = '0;
		{sleepMode, sleepStopSelect, debugMode} = '0;
		keyData = '0;
		clkData = '0;
		ctrlData = '0;
		sourceTick = 4'hf;
		vddLevel = 5'h18;
		extLevel = 5'h18;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		tick(4);
		rst_n <= 1'b1;
		tick(0);
		chk({unlocked, comparatorOn, lowVoltageFlag, irqRequest, svdResetReq}, 5'h0);
		t_lock();
		t_cont();
		t_rsel();
		t_halt(0);
		t_halt(1);
		t_halt(2);
		t_halt(3);
		t_inter();
		conclude();
	end
endmodule
